// file: rtl/hart_master_poll_gateway.sv
// Purpose: Field-link poll master with transparent mode and a Wishbone register file.
// Assumes: All inputs synchronous to clk_i; one reply strobe per request.
// Notes:   Register map in gw_defs.svh; CYC_PER_MS may be cut for simulation.
// Function
// [RQ1] Transparent mode forwards bytes unchanged both ways.
// [RQ2] Transparent mode keeps normal serial port settings.
// [RQ3] Nine baud rates, five parities, two stops.
// [RQ4] Fieldbus I/O sizes come from master only.
// [RQ5] Fieldbus mode uses same clear-or-keep policy.
// [RQ6] Exhausted command clears or keeps its data.
// [RQ7] Button changes fieldbus address while running.
// [RQ8] Master may be primary or secondary.
// [RQ9] Single-point mode polls address zero only.
// [RQ10] Repetition count held, limited zero to five.
// [RQ11] Polling enable cycles through configured commands.
// [RQ12] Starts spaced by 500 to 65535 ms.
// [RQ13] Reply wait limited to 256-65535 ms.
// [RQ14] Timeout resends, then records and advances.
`timescale 1ns/10ps
`include "gw_defs.svh"
module hart_master_poll_gateway
  import gw_pkg::*;
#(
  parameter int N_CMD      = 8,
  parameter int CYC_PER_MS = `MS_NS / `CLK_NS
) (
  // Clock, reset and enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  output logic             irq_o,
  // Serial port side.
  input  byte_t            ser_rx_i,
  output byte_t            ser_tx_o,
  output ser_cfg_t         ser_cfg_o,
  // Field link side.
  input  byte_t            hart_rx_i,
  output byte_t            hart_tx_o,
  output logic             hart_req_v_o,
  output hart_req_t        hart_req_o,
  input  wire logic        hart_rsp_i,
  // Per-command results.
  output logic             cmd_ok_o,
  output logic             cmd_tmo_o,
  output logic             buf_clr_o,
  output logic [$clog2(N_CMD)-1:0] ev_idx_o,
  // Fieldbus slave side.
  input  wire logic [7:0]  pb_in_len_i,
  input  wire logic [7:0]  pb_out_len_i,
  input  wire logic        dp_btn_i,
  output logic [6:0]       dp_addr_o,
  output mode_t            mode_o
);
  localparam int IW = $clog2(N_CMD);

  generate
    if (N_CMD < 2 || N_CMD > 16)
    begin : g_bad
      $error("N_CMD must lie between 2 and 16");
    end
  endgenerate

  // All state of the block.
  typedef struct packed {
    logic                 ack;      // Bus answer.
    logic [31:0]          rdat;     // Read data.
    mode_t                mode;     // Host-side mode.
    logic                 second;   // Secondary master.
    logic                 multi;    // Multi-drop network.
    logic                 poll_en;  // Polling on.
    logic                 clr;      // Clear data on exhaustion.
    logic [3:0]           baud;     // Baud index.
    ser_cfg_t             ser;      // Serial setup.
    logic [2:0]           retry;    // Resends allowed.
    logic [15:0]          poll_ms;  // Start spacing.
    logic [15:0]          resp_ms;  // Reply wait.
    logic [2:0]           sts;      // Sticky events.
    logic [2:0]           mask;     // Event enables.
    logic                 irq;      // Interrupt level.
    logic [6:0]           dpaddr;   // Fieldbus address.
    logic                 btn_q;    // Button, last cycle.
    cmd_ent_t [N_CMD-1:0] tbl;      // Command table.
    logic [IW-1:0]        idx;      // Current command.
    logic [2:0]           tries;    // Resends made.
    poll_st_t             pst;      // Engine state.
    logic                 req_v;    // Request strobe.
    hart_req_t            req;      // Request contents.
    logic                 ok_p;     // Reply pulse.
    logic                 tmo_p;    // Exhaustion pulse.
    logic                 clr_p;    // Clear pulse.
    logic [IW-1:0]        ev_idx;   // Index of the event.
    byte_t                htx;      // Byte to field link.
    byte_t                stx;      // Byte to serial port.
  } state_t;

  state_t s_ff;       // Registered state.
  state_t nxt_s;      // Next state.
  logic   ld_poll;    // Restart the start-spacing timer.
  logic   ld_resp;    // Restart the reply timer.
  logic   poll_done;  // Spacing has elapsed.
  logic   resp_done;  // Reply wait has elapsed.

  // Spacing between request starts.
  ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_poll_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .load_i (ld_poll),
    .ms_i   (s_ff.poll_ms),
    .done_o (poll_done)
  );

  // Wait for a reply.
  ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_resp_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .load_i (ld_resp),
    .ms_i   (s_ff.resp_ms),
    .done_o (resp_done)
  );

  // Merge write data into a word by byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bit-clock divisor for a baud index.
  function automatic logic [19:0] baud_div(input logic [3:0] i);
    case (i)
      4'h0:    baud_div = 20'(`CLK_HZ / 300);
      4'h1:    baud_div = 20'(`CLK_HZ / 600);
      4'h2:    baud_div = 20'(`CLK_HZ / 1200);
      4'h3:    baud_div = 20'(`CLK_HZ / 2400);
      4'h4:    baud_div = 20'(`CLK_HZ / 9600);
      4'h5:    baud_div = 20'(`CLK_HZ / 19200);
      4'h6:    baud_div = 20'(`CLK_HZ / 38400);
      4'h7:    baud_div = 20'(`CLK_HZ / 57600);
      default: baud_div = 20'(`CLK_HZ / 115200);
    endcase
  endfunction : baud_div

  // Next-state logic: bus slave, configuration, poll engine and pass-through.
  always_comb
  begin
    logic          acc;
    logic          wr;
    logic [5:0]    wa;
    logic [31:0]   cur;
    logic [31:0]   w;
    logic [2:0]    ev;
    logic          active;
    logic          adv;
    cmd_ent_t      ent;
    acc       = wb_cyc_i && wb_stb_i && !s_ff.ack;
    wr        = acc && wb_we_i;
    wa        = wb_adr_i[7:2];
    cur       = 32'h0000_0000;
    ev        = 3'h0;
    adv       = 1'b0;
    ent       = s_ff.tbl[s_ff.idx];
    active    = s_ff.poll_en && (s_ff.mode != MODE_UNIV);
    nxt_s     = s_ff;
    ld_poll   = 1'b0;
    ld_resp   = 1'b0;
    nxt_s.ack = acc;
    nxt_s.req_v = 1'b0;
    nxt_s.ok_p  = 1'b0;
    nxt_s.tmo_p = 1'b0;
    nxt_s.clr_p = 1'b0;

    // Present value of the addressed word; unmapped words read zero.
    case (wa)
      `A_CTRL:   cur = {26'h0, s_ff.clr, s_ff.poll_en, s_ff.multi, s_ff.second, s_ff.mode};
      `A_SER:    cur = {23'h0, s_ff.ser.rs232, s_ff.ser.stop2, s_ff.ser.parity, s_ff.baud};
      `A_RETRY:  cur = {29'h0, s_ff.retry};
      `A_POLL:   cur = {16'h0, s_ff.poll_ms};
      `A_RESP:   cur = {16'h0, s_ff.resp_ms};
      `A_STATUS: cur = {29'h0, s_ff.sts};
      `A_MASK:   cur = {29'h0, s_ff.mask};
      `A_INFO:   cur = {8'h0, 8'(s_ff.idx), pb_out_len_i, pb_in_len_i};  // [RQ4]
      `A_DPADDR: cur = {25'h0, s_ff.dpaddr};
      default:
      begin
        if (wa[5:4] == `TBL_BASE && 32'(wa[3:0]) < N_CMD)
        begin
          cur = {16'h0, s_ff.tbl[wa[3:0]].valid, 1'b0,
                 s_ff.tbl[wa[3:0]].addr, s_ff.tbl[wa[3:0]].cmd};
        end
      end
    endcase
    if (acc && !wb_we_i)
    begin
      nxt_s.rdat = cur;
    end
    w = merge(cur, wb_dat_i, wb_sel_i);

    // Register writes; values outside the legal ranges are clamped or dropped.
    if (wr)
    begin
      case (wa)
        `A_CTRL:
        begin
          if (w[`F_MODE] != 2'h3)
          begin
            nxt_s.mode = mode_t'(w[`F_MODE]);
          end
          nxt_s.second  = w[`F_SECOND];  // [RQ8]
          nxt_s.multi   = w[`F_MULTI];   // [RQ9]
          nxt_s.poll_en = w[`F_POLLEN];  // [RQ11]
          nxt_s.clr     = w[`F_CLEAR];   // [RQ5] [RQ6]
        end
        `A_SER:
        begin
          // One serial setup serves every mode, transparent mode included. [RQ2]
          if (w[`F_BAUD] <= `BAUD_LAST)
          begin
            nxt_s.baud    = w[`F_BAUD];
            nxt_s.ser.div = baud_div(w[`F_BAUD]);  // [RQ3]
          end
          if (w[`F_PARITY] <= `PAR_LAST)
          begin
            nxt_s.ser.parity = w[`F_PARITY];  // [RQ3]
          end
          nxt_s.ser.stop2 = w[`F_STOP2];       // [RQ3]
          nxt_s.ser.rs232 = w[`F_RS232];
        end
        `A_RETRY:  nxt_s.retry = (w[2:0] > `RETRY_MAX) ? `RETRY_MAX : w[2:0];  // [RQ10]
        `A_POLL:   nxt_s.poll_ms = (w[15:0] < `POLL_MIN) ? `POLL_MIN : w[15:0];  // [RQ12]
        `A_RESP:   nxt_s.resp_ms = (w[15:0] < `RESP_MIN) ? `RESP_MIN : w[15:0];  // [RQ13]
        `A_MASK:   nxt_s.mask = w[2:0];
        `A_DPADDR:
        begin
          if (w[6:0] <= `DP_MAX)
          begin
            nxt_s.dpaddr = w[6:0];
          end
        end
        default:
        begin
          if (wa[5:4] == `TBL_BASE && 32'(wa[3:0]) < N_CMD)
          begin
            nxt_s.tbl[wa[3:0]].cmd   = w[`F_CMD];
            nxt_s.tbl[wa[3:0]].addr  = w[`F_ADDR];
            nxt_s.tbl[wa[3:0]].valid = w[`F_VALID];
          end
        end
      endcase
    end

    // The button steps the fieldbus address while in fieldbus mode. [RQ7]
    nxt_s.btn_q = dp_btn_i;
    if (dp_btn_i && !s_ff.btn_q && s_ff.mode == MODE_PROFI)
    begin
      nxt_s.dpaddr = (s_ff.dpaddr >= `DP_MAX) ? 7'h00 : s_ff.dpaddr + 7'h01;
    end

    // Poll engine; every start, resend included, waits out the spacing timer.
    case (s_ff.pst)
      P_IDLE:
      begin
        if (!active)
        begin
          nxt_s.tries = 3'h0;
        end
        else if (!ent.valid)
        begin
          adv = 1'b1;  // Empty slots are skipped without using a poll slot.
        end
        else if (poll_done)
        begin
          nxt_s.req_v       = 1'b1;  // [RQ11]
          nxt_s.req.cmd     = ent.cmd;
          nxt_s.req.addr    = s_ff.multi ? ent.addr : 6'h00;  // [RQ9]
          nxt_s.req.primary = !s_ff.second;                   // [RQ8]
          ld_poll           = 1'b1;                           // [RQ12]
          ld_resp           = 1'b1;                           // [RQ13]
          nxt_s.pst         = P_WAIT;
        end
      end
      P_WAIT:
      begin
        if (hart_rsp_i)
        begin
          nxt_s.ok_p = 1'b1;
          ev[0]      = 1'b1;
          adv        = 1'b1;
          nxt_s.pst  = P_IDLE;
        end
        else if (resp_done)
        begin
          nxt_s.pst = P_IDLE;
          if (s_ff.tries < s_ff.retry)
          begin
            nxt_s.tries = s_ff.tries + 3'h1;  // [RQ14]
          end
          else
          begin
            nxt_s.tmo_p = 1'b1;               // [RQ14]
            nxt_s.clr_p = s_ff.clr;           // [RQ5] [RQ6]
            ev[1]       = 1'b1;
            adv         = 1'b1;
          end
        end
      end
      default: nxt_s.pst = P_IDLE;
    endcase
    if (nxt_s.ok_p || nxt_s.tmo_p)
    begin
      nxt_s.ev_idx = s_ff.idx;
    end
    if (adv)
    begin
      nxt_s.tries = 3'h0;
      if (32'(s_ff.idx) == N_CMD - 1)
      begin
        nxt_s.idx = '0;
        ev[2]     = 1'b1;  // One full pass over the table.
      end
      else
      begin
        nxt_s.idx = s_ff.idx + IW'(1);
      end
    end

    // Transparent mode copies bytes through untouched, one cycle late. [RQ1]
    nxt_s.htx.valid = (s_ff.mode == MODE_UNIV) && ser_rx_i.valid;
    nxt_s.htx.data  = ser_rx_i.data;
    nxt_s.stx.valid = (s_ff.mode == MODE_UNIV) && hart_rx_i.valid;
    nxt_s.stx.data  = hart_rx_i.data;

    // Sticky events: a read clears them, but a new event in that cycle stays.
    if (acc && !wb_we_i && wa == `A_STATUS)
    begin
      nxt_s.sts = ev;
    end
    else
    begin
      nxt_s.sts = s_ff.sts | ev;
    end
    nxt_s.irq = |(nxt_s.sts & nxt_s.mask);
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff          <= '0;
      s_ff.mode     <= MODE_MODBUS;
      s_ff.pst      <= P_IDLE;
      s_ff.multi    <= 1'b1;
      s_ff.poll_en  <= 1'b1;
      s_ff.retry    <= `RST_RETRY;
      s_ff.poll_ms  <= `POLL_MIN;
      s_ff.resp_ms  <= `RESP_MIN;
      s_ff.baud     <= `RST_BAUD;
      s_ff.ser.div  <= 20'(`CLK_HZ / 19200);
    end
    else if (ce_i)
    begin
      s_ff <= nxt_s;
    end
  end

  // Every output is a field of the state register.
  assign wb_ack_o     = s_ff.ack;
  assign wb_dat_o     = s_ff.rdat;
  assign irq_o        = s_ff.irq;
  assign ser_tx_o     = s_ff.stx;
  assign ser_cfg_o    = s_ff.ser;
  assign hart_tx_o    = s_ff.htx;
  assign hart_req_v_o = s_ff.req_v;
  assign hart_req_o   = s_ff.req;
  assign cmd_ok_o     = s_ff.ok_p;
  assign cmd_tmo_o    = s_ff.tmo_p;
  assign buf_clr_o    = s_ff.clr_p;
  assign ev_idx_o     = s_ff.ev_idx;
  assign dp_addr_o    = s_ff.dpaddr;
  assign mode_o       = s_ff.mode;
endmodule : hart_master_poll_gateway

// file: rtl/gw_defs.svh
// Purpose: Offsets, field positions, reset values and timing for the poll gateway.
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register.
// Notes:   Definitions only.
`ifndef GW_DEFS_SVH
`define GW_DEFS_SVH
// Register word offsets (byte address bits 7:2).
`define A_CTRL     6'h00
`define A_SER      6'h01
`define A_RETRY    6'h02
`define A_POLL     6'h03
`define A_RESP     6'h04
`define A_STATUS   6'h05
`define A_MASK     6'h06
`define A_INFO     6'h07
`define A_DPADDR   6'h08
`define TBL_BASE   2'h1
// CTRL field positions.
`define F_MODE     1:0
`define F_SECOND   2
`define F_MULTI    3
`define F_POLLEN   4
`define F_CLEAR    5
// SER field positions.
`define F_BAUD     3:0
`define F_PARITY   6:4
`define F_STOP2    7
`define F_RS232    8
// Table entry field positions.
`define F_CMD      7:0
`define F_ADDR     13:8
`define F_VALID    15
// Reset values and limits.
`define RST_RETRY  3'h3
`define RETRY_MAX  3'h5
`define RST_BAUD   4'h5
`define BAUD_LAST  4'h8
`define PAR_LAST   3'h4
`define POLL_MIN   16'h01f4
`define RESP_MIN   16'h0100
`define DP_MAX     7'h7e
// Timing.
`define CLK_HZ     25000000
`define CLK_NS     40
`define MS_NS      1000000
`endif

// file: rtl/gw_pkg.sv
// Purpose: Types shared by the poll gateway files.
// Assumes: Constants live in gw_defs.svh.
// Notes:   Types only.
package gw_pkg;
  // Host-side operating mode.
  typedef enum logic [1:0] {MODE_MODBUS, MODE_UNIV, MODE_PROFI} mode_t;
  // Poll engine states.
  typedef enum logic [0:0] {P_IDLE, P_WAIT} poll_st_t;
  // Serial port setup handed to the line driver.
  typedef struct packed {
    logic [19:0] div;
    logic [2:0]  parity;
    logic        stop2;
    logic        rs232;
  } ser_cfg_t;
  // One byte with its strobe.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_t;
  // One request toward the field link.
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] cmd;
    logic       primary;
  } hart_req_t;
  // One command table entry.
  typedef struct packed {
    logic [7:0] cmd;
    logic [5:0] addr;
    logic       valid;
  } cmd_ent_t;
endpackage : gw_pkg

// file: rtl/ms_timer.sv
// Purpose: Millisecond down-counter that reports expiry as a level.
// Assumes: Load and clock enable are synchronous to clk_i.
// Notes:   Reads as expired after reset.
`timescale 1ns/10ps
module ms_timer #(
  parameter int CYC_PER_MS = 25000
) (
  // Clock and control.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Load of a new span in milliseconds.
  input  wire logic        load_i,
  input  wire logic [15:0] ms_i,
  // Expiry level.
  output logic             done_o
);
  localparam int CW = $clog2(CYC_PER_MS);
  logic [CW-1:0] cyc_ff;  // Cycles into the current millisecond.
  logic [15:0]   ms_ff;   // Milliseconds still to run.

  generate
    if (CYC_PER_MS < 2)
    begin : g_bad
      $error("ms_timer needs at least two cycles per millisecond");
    end
  endgenerate

  // A load restarts the span from a whole millisecond boundary.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cyc_ff <= '0;
      ms_ff  <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (load_i)
      begin
        cyc_ff <= '0;
        ms_ff  <= ms_i;
      end
      else if (ms_ff != 16'h0000)
      begin
        if (cyc_ff == CW'(CYC_PER_MS - 1))
        begin
          cyc_ff <= '0;
          ms_ff  <= ms_ff - 16'h0001;
        end
        else
        begin
          cyc_ff <= cyc_ff + CW'(1);
        end
      end
    end
  end

  assign done_o = (ms_ff == 16'h0000);
endmodule : ms_timer

// file: testbench/gw_checker_properties.sv
// Purpose: Concurrent checks on the poll gateway ports.
// Assumes: ce_i drops only while nothing is in flight; CYC_PER_MS matches the instance.
// Notes:   Bound to the gateway top module at the foot of this file.
`timescale 1ns/10ps
module gw_checker
  import gw_pkg::*;
#(
  parameter int CYC_PER_MS = 4
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Byte streams.
  input  byte_t           ser_rx_i,
  input  byte_t           ser_tx_o,
  input  byte_t           hart_rx_i,
  input  byte_t           hart_tx_o,
  // Poll engine and results.
  input  wire logic       hart_req_v_o,
  input  wire logic       hart_rsp_i,
  input  wire logic       cmd_ok_o,
  input  wire logic       cmd_tmo_o,
  input  wire logic       buf_clr_o,
  input  wire logic [6:0] dp_addr_o,
  input  mode_t           mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shortest legal spacings, less one because the counter starts at zero.
  localparam int POLL_GAP = 500 * CYC_PER_MS - 1;
  localparam int RESP_GAP = 256 * CYC_PER_MS - 1;
  // Cycles since the last request; reset to full so the first request passes.
  logic [19:0] gap_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gap_ff <= 20'hfffff;
    else if (hart_req_v_o)
      gap_ff <= 20'h00000;
    else if (gap_ff != 20'hfffff)
      gap_ff <= gap_ff + 20'h00001;
  end
  // A byte offered while transparent, and one from the field link.
  sequence s_ser_in;
    ser_rx_i.valid && mode_o == MODE_UNIV;
  endsequence
  sequence s_hart_in;
    hart_rx_i.valid && mode_o == MODE_UNIV;
  endsequence
  property p_tx_copy;
    s_ser_in |=> hart_tx_o == $past(ser_rx_i);
  endproperty
  a_tx_copy: assert property (p_tx_copy) else $error("Serial byte not forwarded.");
  property p_rx_copy;
    s_hart_in |=> ser_tx_o == $past(hart_rx_i);
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("Link byte not forwarded.");
  property p_no_fwd;
    (mode_o != MODE_UNIV) [*2] |-> !hart_tx_o.valid;
  endproperty
  a_no_fwd: assert property (p_no_fwd) else $error("Byte forwarded outside transparent.");
  property p_req_pulse;
    hart_req_v_o |=> !hart_req_v_o;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("Request strobe too long.");
  property p_spacing;
    hart_req_v_o |-> gap_ff >= POLL_GAP;
  endproperty
  a_spacing: assert property (p_spacing) else $error("Requests spaced too closely.");
  property p_ok_cause;
    cmd_ok_o |-> $past(hart_rsp_i) && !cmd_tmo_o;
  endproperty
  a_ok_cause: assert property (p_ok_cause) else $error("Success without a reply.");
  property p_tmo_wait;
    cmd_tmo_o |-> gap_ff >= RESP_GAP;
  endproperty
  a_tmo_wait: assert property (p_tmo_wait) else $error("Timeout declared too early.");
  property p_clr_tmo;
    buf_clr_o |-> cmd_tmo_o;
  endproperty
  a_clr_tmo: assert property (p_clr_tmo) else $error("Buffer cleared without timeout.");
  property p_dp_range;
    dp_addr_o <= 7'h7e;
  endproperty
  a_dp_range: assert property (p_dp_range) else $error("Fieldbus address out of range.");
endmodule : gw_checker

bind hart_master_poll_gateway gw_checker #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ser_rx_i(ser_rx_i), .ser_tx_o(ser_tx_o),
  .hart_rx_i(hart_rx_i), .hart_tx_o(hart_tx_o), .hart_req_v_o(hart_req_v_o),
  .hart_rsp_i(hart_rsp_i), .cmd_ok_o(cmd_ok_o), .cmd_tmo_o(cmd_tmo_o),
  .buf_clr_o(buf_clr_o), .dp_addr_o(dp_addr_o), .mode_o(mode_o));

// file: testbench/hart_slave_model.sv
// Purpose: Field slave that answers each request after a set delay, or never.
// Assumes: dly_i is at least one cycle.
// Notes:   A new request restarts the pending reply, as a real slave would.
`timescale 1ns/10ps
module hart_slave_model (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Request in, reply strobe out.
  input  wire logic        req_v_i,
  output logic             rsp_o,
  // Behaviour chosen by the bench.
  input  wire logic        silent_i,
  input  wire logic [15:0] dly_i
);
  // Cycles left until the reply; zero means nothing pending.
  logic [15:0] cnt_ff;
  // A silent slave lets the master run into its timeout.
  always_ff @(posedge clk_i)
  begin
    rsp_o <= 1'b0;
    if (rst_i)
      cnt_ff <= 16'h0000;
    else if (req_v_i && !silent_i)
      cnt_ff <= dly_i;
    else if (cnt_ff == 16'h0001)
    begin
      cnt_ff <= 16'h0000;
      rsp_o  <= 1'b1;
    end
    else if (cnt_ff != 16'h0000)
      cnt_ff <= cnt_ff - 16'h0001;
  end
endmodule : hart_slave_model

// file: testbench/hart_master_poll_gateway_bench.sv
// Purpose: Register, stream and poll checks of the gateway.
// Assumes: CYC_PER_MS is cut to 4 so that poll spacing stays short.
// Notes:   Bus requests hold until ack is sampled high.
`timescale 1ns/10ps
`include "gw_defs.svh"
module hart_master_poll_gateway_bench
  import gw_pkg::*;
;
  // Bench drives and design outputs.
  logic        clk_i, rst_i, cyc, stb, we, btn, rsp, silent, ack, irq, req_v, ok, tmo, clr;
  logic [7:0]  adr;
  logic        ce;
  logic [2:0]  ev_idx;
  logic [3:0]  sel, lanes;
  logic [8:0]  exp_ser;
  logic [31:0] wdat, rd, dat;
  logic [6:0]  dp_addr;
  byte_t       ser_rx, hart_rx, ser_tx, hart_tx;
  ser_cfg_t    cfg;
  hart_req_t   req, last_req;
  mode_t       mode;
  int          n_mismatch, n_tests, n_req, n_ok, n_tmo, n_clr;
  hart_master_poll_gateway #(.N_CMD(8), .CYC_PER_MS(4)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack),
    .wb_dat_o(dat), .irq_o(irq), .ser_rx_i(ser_rx), .ser_tx_o(ser_tx), .ser_cfg_o(cfg),
    .hart_rx_i(hart_rx), .hart_tx_o(hart_tx), .hart_req_v_o(req_v), .hart_req_o(req),
    .hart_rsp_i(rsp), .cmd_ok_o(ok), .cmd_tmo_o(tmo), .buf_clr_o(clr), .ev_idx_o(ev_idx),
    .pb_in_len_i(8'h12), .pb_out_len_i(8'h34), .dp_btn_i(btn), .dp_addr_o(dp_addr),
    .mode_o(mode));
  hart_slave_model slv_u (.clk_i(clk_i), .rst_i(rst_i), .req_v_i(req_v), .rsp_o(rsp),
    .silent_i(silent), .dly_i(16'h0014));
  // Clock of 40 ns.
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Tallies of the one-cycle pulses; sampled at the edge, before updates land.
  always @(posedge clk_i)
  begin
    if (req_v === 1'b1)
    begin
      n_req++;
      last_req = req;
    end
    n_ok  += (ok === 1'b1);
    n_tmo += (tmo === 1'b1);
    n_clr += (clr === 1'b1);
  end
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; a slave that never answers is counted as a mismatch.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= lanes;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n == 50)
      check(32'h1, 32'h0);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rchk
  // Hang guard; the tests need about 10500 cycles.
  initial
  begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    int rate [9] = '{300, 600, 1200, 2400, 9600, 19200, 38400, 57600, 115200};
    logic [7:0]  bytes [4] = '{8'h00, 8'ha5, 8'hff, 8'h5a};
    logic [31:0] tctl [2] = '{32'h38, 32'h1a};
    int n, r0, c0, t0, j;
    {rst_i, ce, cyc, stb, we, btn, silent} = 7'b1100000;
    {sel, lanes} = 8'hff;
    {adr, wdat, ser_rx, hart_rx} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h00, 32'h3f, 32'h18);
    rchk(8'h08, 32'h07, 32'h3);
    rchk(8'h0c, 32'hffff, 32'h1f4);
    rchk(8'h10, 32'hffff, 32'h100);
    wb(1'b1, 8'h08, 32'h7);
    rchk(8'h08, 32'h07, 32'h5);
    wb(1'b1, 8'h0c, 32'h1f3);
    rchk(8'h0c, 32'hffff, 32'h1f4);
    wb(1'b1, 8'h10, 32'hff);
    rchk(8'h10, 32'hffff, 32'h100);
    wb(1'b1, 8'h1c, 32'hffff);
    rchk(8'h1c, 32'hffff, 32'h3412);
    rchk(8'h3c, 32'hffffffff, 32'h0);
    // Only the enabled byte lane of a write may land.
    lanes = 4'h1;
    wb(1'b1, 8'h44, 32'h1234_5655);
    lanes = 4'hf;
    rchk(8'h44, 32'hffff, 32'h55);
    // Every rate and parity; the last write has illegal codes and must be ignored.
    for (int i = 0; i < 10; i++)
    begin
      j = (i < 9) ? i : 8;
      exp_ser = {(i < 9) ? j[1:0] : 2'h0, 3'(j % 5), j[3:0]};
      wb(1'b1, 8'h04, (i < 9) ? 32'(exp_ser) : 32'h5f);
      rchk(8'h04, 32'h1ff, 32'(exp_ser));
      check({cfg.rs232, cfg.stop2, cfg.parity}, 32'(exp_ser[8:4]));
      check(cfg.div, `CLK_HZ / rate[j]);
    end
    wb(1'b1, 8'h00, 32'h1a);
    wb(1'b1, 8'h20, 32'h10);
    btn <= 1'b1;
    repeat (3) @(posedge clk_i);
    btn <= 1'b0;
    repeat (2) @(posedge clk_i);
    // A button edge while the clock enable is low must be lost.
    ce  <= 1'b0;
    btn <= 1'b1;
    repeat (3) @(posedge clk_i);
    ce  <= 1'b1;
    btn <= 1'b0;
    wb(1'b1, 8'h20, 32'h7f);
    rchk(8'h20, 32'h7f, 32'h11);
    check(dp_addr, 7'h11);
    wb(1'b1, 8'h00, 32'h1b);
    check(mode, MODE_PROFI);
    $display("Register tests done");
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h04, 32'h00);
    rchk(8'h04, 32'h0f, 32'h0);
    check(cfg.div, `CLK_HZ / 300);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      ser_rx  <= {1'b1, bytes[i]};
      hart_rx <= {1'b1, ~bytes[i]};
      @(posedge clk_i);
      ser_rx  <= {1'b0, ~bytes[i]};
      hart_rx <= {1'b0, bytes[i]};
      @(posedge clk_i);
      check(hart_tx, {1'b1, bytes[i]});
      check(ser_tx, {1'b1, ~bytes[i]});
    end
    $display("Transparent test done");
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b1, 8'h00, 32'h14);
    r0 = n_ok;
    wb(1'b1, 8'h48, 32'h8503);
    for (n = 0; n < 3000 && n_ok == r0; n++) @(posedge clk_i);
    check(last_req, {6'h00, 8'h03, 1'b0});
    check(ev_idx, 3'h2);
    repeat (3) @(posedge clk_i);
    check(irq, 1'b1);
    rchk(8'h14, 32'h1, 32'h1);
    repeat (3) @(posedge clk_i);
    check(irq, 1'b0);
    $display("Poll reply test done");
    silent <= 1'b1;
    wb(1'b1, 8'h08, 32'h1);
    // Modbus mode clearing, then fieldbus mode keeping.
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, 8'h00, 32'h0);
      repeat (2100) @(posedge clk_i);
      {r0, c0, t0} = {n_req, n_clr, n_tmo};
      wb(1'b1, 8'h00, tctl[k]);
      for (n = 0; n < 12000 && n_tmo == t0; n++) @(posedge clk_i);
      check(n_tmo - t0, 1);
      check(n_req - r0, 2);
      check(n_clr - c0, k == 0);
      check(last_req, {6'h05, 8'h03, 1'b1});
      $display("Timeout test %0d done", k);
    end
    check(irq, 1'b0);
    end_of_test();
  end
endmodule : hart_master_poll_gateway_bench
